//--- src/store_pkg.sv
`default_nettype none
package store_pkg;
   // Store geometry.
   localparam int STORE_DEPTH   = 128;
   localparam int STORE_ADDR_W  = 7;
   localparam int WORD_W        = 30;
   localparam int BYTE_PORTS    = 4;
   // Field positions inside a stored word, low end first.
   localparam int SRCDST_LSB    = 0;
   localparam int SRCDST_W      = 6;
   localparam int COUNT_LSB     = 6;
   localparam int COUNT_W       = 4;
   localparam int PHASE_LSB     = 10;
   localparam int PHASE_W       = 4;
   localparam int EXEC_LSB      = 14;
   localparam int EXEC_W        = 12;
   localparam int GENCTL_LSB    = 26;
   localparam int GENCTL_W      = 4;
   // Bit of the source/destination field that picks the path.
   localparam int PATH_BIT      = 5;
   // Sequencer step length in input clocks.
   localparam int STEP_CLOCKS   = 4;
   // Byte port select codes.
   localparam logic [1:0] PORT_ZERO  = 2'h0;
   localparam logic [1:0] PORT_THREE = 2'h3;
   // Count codes.
   localparam logic [3:0] COUNT_ZERO = 4'h0;
   localparam logic [3:0] COUNT_MAX  = 4'he;

   // Decoded instruction fields.
   typedef struct packed {
      logic [3:0]  gen_ctl;
      logic [11:0] exec_ctl;
      logic [3:0]  bus_phase;
      logic [3:0]  count;
      logic [5:0]  src_dst;
   } instr_t;

   // Microprocessor access to the store ports.
   typedef struct packed {
      logic       addr_wr;
      logic       port_wr;
      logic [1:0] port_sel;
      logic [7:0] wdata;
   } cpu_req_t;

   typedef enum logic [1:0] {
      SEQ_FETCH,
      SEQ_MOVE,
      SEQ_NEXT
   } seq_state_t;
endpackage
`default_nettype wire

//--- src/scsi_microcode_store_port.sv
`default_nettype none
module scsi_microcode_store_port
   import store_pkg::*;
#(
   parameter int DEPTH  = STORE_DEPTH,
   parameter int ADDR_W = STORE_ADDR_W
)
(
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              nrst,
   // Processor port.
   input  wire cpu_req_t          cpu_req,
   output logic [7:0]             store_read_port,
   // Sequencer control.
   input  wire logic              seq_run,
   output logic                   seq_running,
   output logic [ADDR_W-1:0]      seq_pc,
   output instr_t                 seq_instr,
   // Data movement strobes.
   output logic                   regfile_byte_stb,
   output logic                   pipeline_xfer_stb,
   output logic                   fifo_byte_stb,
   output logic                   dma_port_sel
);

   logic [WORD_W-1:0]   microcode_store [DEPTH];
   logic [ADDR_W-1:0]   store_address_pointer_reg, store_address_pointer_next;
   logic [7:0]          stage0_reg, stage0_next;
   logic [7:0]          stage1_reg, stage1_next;
   logic [7:0]          stage2_reg, stage2_next;
   logic [7:0]          rdata_reg, rdata_next;
   logic                store_we;
   logic [31:0]         assembled;
   logic [WORD_W-1:0]   rd_word;
   logic [1:0]          tick_reg, tick_next;
   logic                step_en;
   seq_state_t          state_reg, state_next;
   logic [ADDR_W-1:0]   pc_reg, pc_next;
   instr_t              instr_reg, instr_next;
   logic [3:0]          left_reg, left_next;
   logic                rf_stb_reg, rf_stb_next;
   logic                tc_stb_reg, tc_stb_next;
   logic                running_reg, running_next;

   // Field split of a raw store word.
   function automatic instr_t decode(input logic [WORD_W-1:0] w);
      instr_t d;
      d.src_dst   = w[SRCDST_LSB +: SRCDST_W];
      d.count     = w[COUNT_LSB +: COUNT_W];
      d.bus_phase = w[PHASE_LSB +: PHASE_W];
      d.exec_ctl  = w[EXEC_LSB +: EXEC_W];
      d.gen_ctl   = w[GENCTL_LSB +: GENCTL_W];
      return d;
   endfunction

   // Word assembled from the three staged bytes and the byte now on port three.
   assign assembled = {cpu_req.wdata, stage2_reg, stage1_reg, stage0_reg};
   assign store_we  = cpu_req.port_wr && (cpu_req.port_sel == PORT_THREE);

   // Processor side: pointer, staging bytes and read byte select.
   always_comb
   begin
      store_address_pointer_next = store_address_pointer_reg;
      stage0_next = stage0_reg;
      stage1_next = stage1_reg;
      stage2_next = stage2_reg;
      if (cpu_req.addr_wr)
      begin
         store_address_pointer_next = cpu_req.wdata[ADDR_W-1:0];
      end
      else if (store_we)
      begin
         store_address_pointer_next = store_address_pointer_reg + 1'b1;
      end
      if (cpu_req.port_wr)
      begin
         case (cpu_req.port_sel)
            PORT_ZERO: stage0_next = cpu_req.wdata;
            2'h1:      stage1_next = cpu_req.wdata;
            2'h2:      stage2_next = cpu_req.wdata;
            default:   stage2_next = stage2_reg;
         endcase
      end
      // The read byte comes from the pointed word; only valid while halted.
      rdata_next = rd_word[7:0];
      case (cpu_req.port_sel)
         2'h1:    rdata_next = rd_word[15:8];
         2'h2:    rdata_next = rd_word[23:16];
         PORT_THREE: rdata_next = {2'h0, rd_word[WORD_W-1:24]};
         default: rdata_next = rd_word[7:0];
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         store_address_pointer_reg <= '0;
         stage0_reg <= 8'h00;
         stage1_reg <= 8'h00;
         stage2_reg <= 8'h00;
         rdata_reg  <= 8'h00;
      end
      else
      begin
         store_address_pointer_reg <= store_address_pointer_next;
         stage0_reg <= stage0_next;
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
         rdata_reg  <= rdata_next;
      end
   end

   // Store array has no reset; it is loaded by software before use.
   always_ff @(posedge clk)
   begin
      if (store_we)
      begin
         microcode_store[store_address_pointer_reg] <= assembled[WORD_W-1:0];
      end
   end

   // The array is shared: while running the sequencer owns the read address,
   // so processor reads then return whatever the sequencer fetched.
   assign rd_word = running_reg ? microcode_store[pc_reg]
                                : microcode_store[store_address_pointer_reg];
   assign store_read_port = rdata_reg;

   // Step divider: one enable every four clocks.
   always_comb
   begin
      tick_next = running_reg ? tick_reg + 1'b1 : 2'h0;
      step_en   = running_reg && (tick_reg == 2'(STEP_CLOCKS - 1));
   end

   // Sequencer: fetch, move the counted bytes (register file path) or issue one pipeline request, then advance.
   always_comb
   begin
      state_next   = state_reg;
      pc_next      = pc_reg;
      instr_next   = instr_reg;
      left_next    = left_reg;
      rf_stb_next  = 1'b0;
      tc_stb_next  = 1'b0;
      running_next = seq_run;
      if (!running_reg)
      begin
         state_next = SEQ_FETCH;
         pc_next    = store_address_pointer_reg;
      end
      else if (step_en)
      begin
         case (state_reg)
            SEQ_FETCH:
            begin
               instr_next = decode(rd_word);
               left_next  = rd_word[COUNT_LSB +: COUNT_W];
               // A zero count moves nothing on either path.
               state_next = (rd_word[COUNT_LSB +: COUNT_W] == COUNT_ZERO)
                            ? SEQ_NEXT : SEQ_MOVE;
            end
            SEQ_MOVE:
            begin
               if (instr_reg.src_dst[PATH_BIT])
               begin
                  // Counts above fourteen are not byte counts and move nothing here.
                  if (left_reg != COUNT_ZERO && instr_reg.count <= COUNT_MAX)
                  begin
                     rf_stb_next = 1'b1;
                     left_next   = left_reg - 1'b1;
                  end
                  state_next = (left_reg <= 4'h1 || instr_reg.count > COUNT_MAX)
                               ? SEQ_NEXT : SEQ_MOVE;
               end
               else
               begin
                  // Pipeline sizes the transfer itself; one request per instruction.
                  tc_stb_next = 1'b1;
                  state_next  = SEQ_NEXT;
               end
            end
            SEQ_NEXT:
            begin
               pc_next    = pc_reg + 1'b1;
               state_next = SEQ_FETCH;
            end
            default: state_next = SEQ_FETCH;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tick_reg    <= 2'h0;
         state_reg   <= SEQ_FETCH;
         pc_reg      <= '0;
         instr_reg   <= '0;
         left_reg    <= 4'h0;
         rf_stb_reg  <= 1'b0;
         tc_stb_reg  <= 1'b0;
         running_reg <= 1'b0;
      end
      else
      begin
         tick_reg    <= tick_next;
         state_reg   <= state_next;
         pc_reg      <= pc_next;
         instr_reg   <= instr_next;
         left_reg    <= left_next;
         rf_stb_reg  <= rf_stb_next;
         tc_stb_reg  <= tc_stb_next;
         running_reg <= running_next;
      end
   end

   // Both paths feed the internal FIFO; only the pipeline path uses the DMA port.
   assign regfile_byte_stb  = rf_stb_reg;
   assign pipeline_xfer_stb = tc_stb_reg;
   assign fifo_byte_stb     = rf_stb_reg | tc_stb_reg;
   assign dma_port_sel      = tc_stb_reg;
   assign seq_running = running_reg;
   assign seq_pc      = pc_reg;
   assign seq_instr   = instr_reg;

endmodule
`default_nettype wire

//--- bench/store_port_properties.sv
`default_nettype none
module store_port_checker
   import store_pkg::*;
#(
   parameter int ADDR_W = STORE_ADDR_W
)
(
   // Clock and reset.
   input wire logic              clk,
   input wire logic              nrst,
   // Watched ports.
   input wire cpu_req_t          cpu_req,
   input wire logic [7:0]        store_read_port,
   input wire logic              seq_run,
   input wire logic              seq_running,
   input wire logic [ADDR_W-1:0] seq_pc,
   input wire instr_t            seq_instr,
   input wire logic              regfile_byte_stb,
   input wire logic              pipeline_xfer_stb,
   input wire logic              fifo_byte_stb,
   input wire logic              dma_port_sel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Strobes are tied to each other, to the path bit and count of the fetched word, and to the step; running follows the run request.
   fifo_or_a: assert property (fifo_byte_stb == (regfile_byte_stb | pipeline_xfer_stb))
      else $error("fifo strobe differs from path strobes");
   dma_select_a: assert property (dma_port_sel == pipeline_xfer_stb)
      else $error("dma select differs from pipeline strobe");
   rf_path_a: assert property (regfile_byte_stb |-> seq_instr.src_dst[PATH_BIT])
      else $error("register file strobe on pipeline path");
   pipe_path_a: assert property (pipeline_xfer_stb |-> !seq_instr.src_dst[PATH_BIT])
      else $error("pipeline strobe on register file path");
   zero_count_a: assert property (seq_instr.count == COUNT_ZERO |-> !fifo_byte_stb)
      else $error("data moved on zero count");
   count_f_a: assert property (seq_instr.count == 4'hf |-> !regfile_byte_stb)
      else $error("register file byte on count f");
   step_gap_a: assert property (regfile_byte_stb |=> !regfile_byte_stb [*3])
      else $error("register file strobes closer than one step");
   run_follow_a: assert property ($past(nrst, 2) |-> seq_running == $past(seq_run))
      else $error("running flag does not follow run request");
   // Main scenarios seen.
   cover property (regfile_byte_stb ##4 regfile_byte_stb);
   cover property (pipeline_xfer_stb);
   cover property (cpu_req.port_wr && cpu_req.port_sel == PORT_THREE);
endmodule
`default_nettype wire

//--- bench/store_cpu_model.sv
`default_nettype none
module store_cpu_model
   import store_pkg::*;
(
   // Clock.
   input  wire logic       clk,
   // Store port.
   output var cpu_req_t    cpu_req,
   input  wire logic [7:0] store_read_port
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cpu_req = '0;
   // Optional pointer load, then n bytes from port zero upward.
   task automatic put_word(input logic ld, input logic [6:0] a, input logic [31:0] w,
                           input int n);
      if (ld)
         @(posedge clk) cpu_req <= '{1'b1, 1'b0, 2'h0, {1'b0, a}};
      for (int i = 0; i < n; i++)
         @(posedge clk) cpu_req <= '{1'b0, 1'b1, i[1:0], w[8*i +: 8]};
      // Idle data is inverted so a stale byte is never mistaken for a fresh one.
      @(posedge clk) cpu_req <= '{1'b0, 1'b0, 2'h0, ~cpu_req.wdata};
   endtask
   // Select a byte, then take it once the registered answer has settled.
   task automatic get_byte(input int i, output logic [7:0] b);
      @(posedge clk) cpu_req.port_sel <= i[1:0];
      repeat (2) @(posedge clk);
      #1 b = store_read_port;
   endtask
endmodule
`default_nettype wire

//--- bench/test_scsi_microcode_store_port.sv
`default_nettype none
module test_scsi_microcode_store_port import store_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, nrst, seq_run, seq_running, regfile_byte_stb, pipeline_xfer_stb;
   logic        fifo_byte_stb, dma_port_sel;
   logic [7:0]  store_read_port, b;
   logic [6:0]  seq_pc;
   instr_t      seq_instr;
   cpu_req_t    cpu_req;
   logic [29:0] mem [128];
   logic [31:0] w, seed;
   int          n_fail, check_count, nr, np;
   scsi_microcode_store_port uut (.clk, .nrst, .cpu_req, .store_read_port, .seq_run,
      .seq_running, .seq_pc, .seq_instr, .regfile_byte_stb, .pipeline_xfer_stb,
      .fifo_byte_stb, .dma_port_sel);
   store_cpu_model host (.clk, .cpu_req, .store_read_port);
   // Free running 250 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Byte as the read port shows it; the top two bits never come back.
   function automatic logic [7:0] exp_byte(input logic [29:0] v, input int i);
      return (i == 3) ? {2'h0, v[29:24]} : v[8*i +: 8];
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (n_fail == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Halted reads of a whole word at address a.
   task automatic read_word(input logic [6:0] a);
      host.put_word(1'b1, a, 32'h0, 0);
      for (int i = 0; i < 4; i++)
      begin
         host.get_byte(i, b);
         check(b, exp_byte(mem[a], i));
      end
   endtask
   // Run one instruction at address 40 and count its strobes.
   task automatic run_one(input logic p, input logic [3:0] c);
      w = $random(seed);
      w[5] = p;
      w[9:6] = c;
      mem[40] = w[29:0];
      host.put_word(1'b1, 7'd40, w, 4);
      host.put_word(1'b1, 7'd40, 32'h0, 0);
      nr = 0;
      np = 0;
      @(posedge clk) seq_run <= 1'b1;
      // The first step fetches; by cycle 8 the word at 40 must be decoded and pc still 40.
      for (int t = 1; t <= 120; t++)
      begin
         @(posedge clk);
         #1 nr += regfile_byte_stb;
         np += pipeline_xfer_stb;
         if (t == 8)
         begin
            check(seq_pc, 32'd40);
            check(seq_instr, w[29:0]);
         end
      end
      @(posedge clk) seq_run <= 1'b0;
      repeat (8) @(posedge clk);
      check(nr, (p && c != COUNT_ZERO && c != 4'hf) ? c : 0);
      check(np, (!p && c != COUNT_ZERO) ? 1 : 0);
   endtask
   // Hang guard.
   initial
   begin
      repeat (30000) @(posedge clk);
      n_fail++;
      summarize();
   end
   // Main sequence.
   initial
   begin
      seed = 32'hd5bbb45a;
      n_fail = 0;
      check_count = 0;
      nrst = 1'b0;
      seq_run = 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      // One pointer load, then 128 words, the last 127 placed by the increment; all zero count.
      for (int a = 0; a < 128; a++)
      begin
         w = $random(seed);
         w[9:6] = COUNT_ZERO;
         mem[a] = w[29:0];
         host.put_word(a == 0, 7'd0, w, 4);
      end
      for (int k = 0; k < 12; k++)
         read_word(k < 2 ? 7'(k * 127) : 7'($random(seed)));
      // Three staged bytes alone leave the stored word untouched.
      host.put_word(1'b1, 7'd5, ~{2'h0, mem[5]}, 3);
      read_word(7'd5);
      for (int i = 0; i < 8; i++)
         run_one(i[0], 4'(i < 6 ? 15 * i[2] + (i[1] ? 14 : 1) * i[1] : $random(seed)));
      run_one(1'b1, 4'hf);
      run_one(1'b1, 4'he);
      summarize();
   end
endmodule
bind scsi_microcode_store_port store_port_checker #(.ADDR_W(ADDR_W)) chk (.clk, .nrst,
   .cpu_req, .store_read_port, .seq_run, .seq_running, .seq_pc, .seq_instr,
   .regfile_byte_stb, .pipeline_xfer_stb, .fifo_byte_stb, .dma_port_sel);
`default_nettype wire
